// ===== core/adc_aux_gain_offset_cal.sv
// Gain and offset calibration of auxiliary channel conversion results
// Contract
// - At amplifier gain 2, auxiliary results are scaled by the gain-2 coefficient, other channels untouched.
// - At amplifier gain 4, auxiliary results are scaled by the gain-4 coefficient, other channels untouched.
// - Each gain coefficient is an unsigned 15-bit field: a top integer bit and fourteen fraction bits.
// - Coefficient 0x4000 is a multiplier of exactly one and is the default.
// - Coefficient zero is illegal and forces a zero result; software must not write it.
// - Coefficient 0x2000 halves the result.
// - Codes 0x4001 up to 0x7fff raise the multiplier in steps of 2^-14 up to about two.
// - Codes 0x0001 up to 0x3fff lower it, the multiplier being code / 0x4000.
// - At amplifier gain 4 the programmed offset is added to auxiliary results.
// - The offset is a signed 15-bit value in quarter LSB units.
// - An offset of zero leaves the result free of adjustment.
// - The gain-2 coefficient resets to unity.
// - The gain-4 offset resets to zero.
`timescale 1ns/1ps
module adc_aux_gain_offset_cal #(
    parameter int DATA_W = 16,
    parameter int COEF_W = 15
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    input wire logic [2:0] pga_gain_sel,
    input wire logic aux_channel,
    output logic cal_valid,
    output logic [DATA_W-1:0] cal_data
);
    typedef struct packed {
        logic [COEF_W-1:0] gain_cal_amp_x2;
        logic [COEF_W-1:0] gain_cal_amp_x4;
        logic [COEF_W-1:0] offset_cal_amp_x4;
        logic [31:0] rdata;
        logic out_valid;
        logic [DATA_W-1:0] out_data;
        logic [DATA_W-1:0] last_result;
        logic sat_seen;
    } cal_state_s;

    cal_state_s state;
    cal_state_s next_state;
    logic [COEF_W-1:0] sel_coef;
    logic [COEF_W-1:0] sel_offset;
    logic mul_valid;
    logic [DATA_W-1:0] mul_data;
    logic mul_sat;

    // Coefficient choice; non-auxiliary channels and other gains pass at unity
    always_comb begin
        sel_coef = aux_cal_pkg::GAIN_RESET;
        sel_offset = aux_cal_pkg::OFFSET_RESET;
        if (aux_channel && pga_gain_sel == aux_cal_pkg::PGA_GAIN_2) begin
            sel_coef = state.gain_cal_amp_x2;
        end else if (aux_channel && pga_gain_sel == aux_cal_pkg::PGA_GAIN_4) begin
            sel_coef = state.gain_cal_amp_x4;
            sel_offset = state.offset_cal_amp_x4;
        end
    end

    cal_mul_sat #(
        .DATA_W(DATA_W),
        .COEF_W(COEF_W)
    ) u_mul (
        .clk(clk),
        .rstn(rstn),
        .in_valid(raw_valid),
        .in_data(raw_data),
        .coef(sel_coef),
        .offset(sel_offset),
        .res_valid(mul_valid),
        .res_data(mul_data),
        .res_sat(mul_sat)
    );

    // Register file, read port and result capture
    always_comb begin
        next_state = state;
        next_state.rdata = '0;
        next_state.out_valid = mul_valid;
        if (mul_valid) begin
            next_state.out_data = mul_data;
            next_state.last_result = mul_data;
        end
        if (wr_en) begin
            unique case (addr)
                aux_cal_pkg::OFS_GAIN_CAL_AMP_X2:
                    next_state.gain_cal_amp_x2 = wdata[aux_cal_pkg::COEF_LSB +: COEF_W];
                aux_cal_pkg::OFS_GAIN_CAL_AMP_X4:
                    next_state.gain_cal_amp_x4 = wdata[aux_cal_pkg::COEF_LSB +: COEF_W];
                aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4:
                    next_state.offset_cal_amp_x4 = wdata[aux_cal_pkg::COEF_LSB +: COEF_W];
                aux_cal_pkg::OFS_CAL_STATUS: begin
                    if (wdata[aux_cal_pkg::STATUS_SAT_BIT]) begin
                        next_state.sat_seen = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // A saturation in the clearing cycle is kept
        if (mul_sat) begin
            next_state.sat_seen = 1'b1;
        end
        if (rd_en) begin
            unique case (addr)
                aux_cal_pkg::OFS_GAIN_CAL_AMP_X2:
                    next_state.rdata = 32'(state.gain_cal_amp_x2);
                aux_cal_pkg::OFS_GAIN_CAL_AMP_X4:
                    next_state.rdata = 32'(state.gain_cal_amp_x4);
                aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4:
                    next_state.rdata = 32'(state.offset_cal_amp_x4);
                aux_cal_pkg::OFS_CAL_STATUS: begin
                    next_state.rdata[DATA_W-1:0] = state.last_result;
                    next_state.rdata[aux_cal_pkg::STATUS_SAT_BIT] = state.sat_seen;
                end
                default:
                    next_state.rdata = '0;
            endcase
        end
        // Unity gain and no offset until software calibrates
        if (!rstn) begin
            next_state = '0;
            next_state.gain_cal_amp_x2 = aux_cal_pkg::GAIN_RESET;
            next_state.gain_cal_amp_x4 = aux_cal_pkg::GAIN_RESET;
            next_state.offset_cal_amp_x4 = aux_cal_pkg::OFFSET_RESET;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    assign rdata = state.rdata;
    assign cal_valid = state.out_valid;
    assign cal_data = state.out_data;

    // Reference model for checks: offset then gain, round half up, clamp
    function automatic logic [DATA_W-1:0] ref_cal(input logic [DATA_W-1:0] x,
                                                  input logic [COEF_W-1:0] c,
                                                  input logic [COEF_W-1:0] o);
        longint s;
        longint p;
        s = longint'(x) * 4 + longint'($signed(o));
        p = (s * longint'(c) + 32768) >>> 16;
        if (p < 0) begin
            p = 0;
        end
        if (p > 65535) begin
            p = 65535;
        end
        return p[DATA_W-1:0];
    endfunction

    logic chk_x2;
    logic chk_x4;
    assign chk_x2 = raw_valid && aux_channel && pga_gain_sel == aux_cal_pkg::PGA_GAIN_2;
    assign chk_x4 = raw_valid && aux_channel && pga_gain_sel == aux_cal_pkg::PGA_GAIN_4;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_gain_x2_path;
        chk_x2 |-> ##2 cal_valid && cal_data == ref_cal($past(raw_data, 2), $past(state.gain_cal_amp_x2, 2), 15'h0);
    endproperty
    a_gain_x2_path: assert property (p_gain_x2_path) else $error("gain 2 result wrong");

    property p_gain_x4_path;
        chk_x4 |-> ##2 cal_valid
            && cal_data == ref_cal($past(raw_data, 2), $past(state.gain_cal_amp_x4, 2),
                                   $past(state.offset_cal_amp_x4, 2));
    endproperty
    a_gain_x4_path: assert property (p_gain_x4_path) else $error("gain 4 result wrong");

    property p_bypass;
        raw_valid && !chk_x2 && !chk_x4 |-> ##2 cal_valid && cal_data == $past(raw_data, 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass channel altered");

    property p_unity;
        chk_x4 && state.gain_cal_amp_x4 == 15'h4000 && state.offset_cal_amp_x4 == 15'h0
            |-> ##2 cal_data == $past(raw_data, 2);
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain changed result");

    property p_zero_coef;
        chk_x2 && state.gain_cal_amp_x2 == 15'h0 |-> ##2 cal_valid && cal_data == 16'h0;
    endproperty
    a_zero_coef: assert property (p_zero_coef) else $error("zero coefficient not zero");

    property p_half;
        chk_x2 && state.gain_cal_amp_x2 == 15'h2000
            |-> ##2 cal_data == 16'((17'($past(raw_data, 2)) + 17'h1) >> 1);
    endproperty
    a_half: assert property (p_half) else $error("half gain wrong");

    property p_no_wrap;
        chk_x2 && raw_data == 16'hffff && state.gain_cal_amp_x2 > 15'h4000 |-> ##2 cal_data == 16'hffff;
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("result wrapped");

    property p_reset_coefs;
        $rose(rstn) |-> state.gain_cal_amp_x2 == 15'h4000 && state.offset_cal_amp_x4 == 15'h0;
    endproperty
    a_reset_coefs: assert property (p_reset_coefs) else $error("bad reset coefficients");

    property p_write_field;
        wr_en && addr == aux_cal_pkg::OFS_GAIN_CAL_AMP_X4 ##1 rd_en && addr == aux_cal_pkg::OFS_GAIN_CAL_AMP_X4
            |=> rdata == {17'h0, $past(wdata[14:0], 2)};
    endproperty
    a_write_field: assert property (p_write_field) else $error("coefficient readback wrong");

    property p_reserved_zero;
        rd_en |=> rdata[31:17] == 15'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    // Read data stand for one cycle only and return to zero
    property p_rdata_idle;
        !rd_en |=> rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    // Coefficient readback carries the stored code and nothing above it
    property p_read_gain_x2;
        rd_en && addr == aux_cal_pkg::OFS_GAIN_CAL_AMP_X2 |=> rdata == {17'h0, $past(state.gain_cal_amp_x2)};
    endproperty
    a_read_gain_x2: assert property (p_read_gain_x2) else $error("gain 2 readback wrong");

    // Writes to places with no coefficient leave every coefficient alone
    property p_unmapped_write;
        wr_en && addr != aux_cal_pkg::OFS_GAIN_CAL_AMP_X2 && addr != aux_cal_pkg::OFS_GAIN_CAL_AMP_X4
            && addr != aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4
            |=> $stable(state.gain_cal_amp_x2) && $stable(state.gain_cal_amp_x4) && $stable(state.offset_cal_amp_x4);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a coefficient");

    // One result for every sample two edges later, and none without a sample
    property p_valid_latency;
        raw_valid |-> ##2 cal_valid;
    endproperty
    a_valid_latency: assert property (p_valid_latency) else $error("result pulse missing");

    property p_no_spurious_valid;
        !raw_valid |-> ##2 !cal_valid;
    endproperty
    a_no_spurious_valid: assert property (p_no_spurious_valid) else $error("result pulse without sample");

    // The result word holds between pulses so a slow reader still sees it
    property p_hold_result;
        !cal_valid |-> $stable(cal_data);
    endproperty
    a_hold_result: assert property (p_hold_result) else $error("result changed without pulse");

    // Saturation sets the sticky flag; a clear with no saturation drops it
    property p_sat_sets_flag;
        mul_sat |=> state.sat_seen;
    endproperty
    a_sat_sets_flag: assert property (p_sat_sets_flag) else $error("saturation flag not set");

    property p_status_clear;
        wr_en && addr == aux_cal_pkg::OFS_CAL_STATUS && wdata[aux_cal_pkg::STATUS_SAT_BIT] && !mul_sat
            |=> !state.sat_seen;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("saturation flag not cleared");

    property p_status_read;
        rd_en && addr == aux_cal_pkg::OFS_CAL_STATUS
            |=> rdata == {15'h0, $past(state.sat_seen), $past(state.last_result)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status readback wrong");

    // End points of the gain and offset codes
    property p_max_gain;
        chk_x2 && state.gain_cal_amp_x2 == 15'h7fff && raw_data == 16'h1000 |-> ##2 cal_data == 16'h2000;
    endproperty
    a_max_gain: assert property (p_max_gain) else $error("largest gain code wrong");

    property p_min_gain;
        chk_x2 && state.gain_cal_amp_x2 == 15'h0001 && raw_data == 16'hffff |-> ##2 cal_data == 16'h0004;
    endproperty
    a_min_gain: assert property (p_min_gain) else $error("smallest gain code wrong");

    property p_low_clamp;
        chk_x4 && state.offset_cal_amp_x4 == 15'h4000 && raw_data == 16'h0000 |-> ##2 cal_data == 16'h0000;
    endproperty
    a_low_clamp: assert property (p_low_clamp) else $error("negative result not clamped");

    property p_reset_gain_x4;
        $rose(rstn) |-> state.gain_cal_amp_x4 == 15'h4000;
    endproperty
    a_reset_gain_x4: assert property (p_reset_gain_x4) else $error("bad gain 4 reset value");

    c_gain_x2: cover property (chk_x2 ##2 cal_valid);
    c_gain_x4_offset: cover property (chk_x4 && state.offset_cal_amp_x4 != 15'h0 ##2 cal_valid);
    c_saturate: cover property (mul_sat);
    c_status_read: cover property (rd_en && addr == aux_cal_pkg::OFS_CAL_STATUS);
    c_back_to_back: cover property (wr_en ##1 rd_en);
endmodule

// ===== core/aux_cal_pkg.sv
// Constants shared by the auxiliary channel calibration stage
package aux_cal_pkg;
    // Register byte offsets
    localparam logic [15:0] OFS_GAIN_CAL_AMP_X2 = 16'h2274;
    localparam logic [15:0] OFS_GAIN_CAL_AMP_X4 = 16'h2278;
    localparam logic [15:0] OFS_OFFSET_CAL_AMP_X4 = 16'h22d4;
    localparam logic [15:0] OFS_CAL_STATUS = 16'h22f0;
    // Field layout
    localparam int COEF_W = 15;
    localparam int COEF_LSB = 0;
    localparam int DATA_W = 16;
    localparam int FRAC_BITS = 14;
    localparam int QUARTER_BITS = 2;
    localparam int STATUS_SAT_BIT = 16;
    // Reset values
    localparam logic [14:0] GAIN_RESET = 15'h4000;
    localparam logic [14:0] OFFSET_RESET = 15'h0000;
    // Amplifier gain selector codes
    localparam logic [2:0] PGA_GAIN_1 = 3'h0;
    localparam logic [2:0] PGA_GAIN_1P5 = 3'h1;
    localparam logic [2:0] PGA_GAIN_2 = 3'h2;
    localparam logic [2:0] PGA_GAIN_4 = 3'h3;
    localparam logic [2:0] PGA_GAIN_9 = 3'h4;
    // Data path latency in clock edges from sample to result
    localparam int CAL_LATENCY = 2;
endpackage

// ===== core/cal_mul_sat.sv
// Offset add, fixed point gain multiply, rounding and saturation
`timescale 1ns/1ps
module cal_mul_sat #(
    parameter int DATA_W = 16,
    parameter int COEF_W = 15
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [DATA_W-1:0] in_data,
    input wire logic [COEF_W-1:0] coef,
    input wire logic [COEF_W-1:0] offset,
    output logic res_valid,
    output logic [DATA_W-1:0] res_data,
    output logic res_sat
);
    localparam int SUM_W = DATA_W + 4;
    localparam int PROD_W = SUM_W + COEF_W + 1;
    localparam int SHIFT = aux_cal_pkg::FRAC_BITS + aux_cal_pkg::QUARTER_BITS;

    typedef struct packed {
        logic valid;
        logic signed [SUM_W-1:0] sum;
        logic [COEF_W-1:0] coef;
    } mul_state_s;

    mul_state_s state;
    mul_state_s next_state;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] rounded;
    logic signed [PROD_W-SHIFT-1:0] scaled;

    // Offset goes in first, in quarter LSB units, so it is scaled with the gain
    always_comb begin
        next_state = state;
        next_state.valid = in_valid;
        if (in_valid) begin
            next_state.sum = $signed({2'b00, in_data, 2'b00}) + SUM_W'($signed(offset));
            next_state.coef = coef;
        end
        if (!rstn) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    // Multiplier is coef / 2^14; a zero code gives a zero product
    assign prod = PROD_W'(state.sum) * $signed({1'b0, state.coef});
    assign rounded = prod + (PROD_W'(1) <<< (SHIFT - 1));
    assign scaled = rounded[PROD_W-1:SHIFT];

    // Clamp to the output word rather than wrap
    always_comb begin
        res_valid = state.valid;
        res_sat = 1'b0;
        res_data = scaled[DATA_W-1:0];
        if (scaled < 0) begin
            res_data = '0;
            res_sat = state.valid;
        end else if (scaled > $signed({1'b0, {DATA_W{1'b1}}})) begin
            res_data = '1;
            res_sat = state.valid;
        end
    end
endmodule

// ===== testbench/tb_adc_aux_gain_offset_cal.sv
// Self-checking bench for the auxiliary channel gain and offset calibration stage
`timescale 1ns/1ps
module tb_adc_aux_gain_offset_cal;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic raw_valid = 1'b0;
    logic [15:0] raw_data = 16'h0000;
    logic [2:0] pga_gain_sel = 3'h0;
    logic aux_channel = 1'b0;
    logic cal_valid;
    logic [15:0] cal_data;
    logic [14:0] g2 = 15'h4000;
    logic [14:0] g4 = 15'h4000;
    logic [14:0] o4 = 15'h0000;
    logic [1:0] vh = 2'b00;
    logic [15:0] expq[$];
    int errors = 0;
    int n_tests = 0;
    logic [14:0] gtab[7] = '{15'h0000, 15'h2000, 15'h4000, 15'h4001, 15'h7fff, 15'h0001, 15'h3fff};
    logic [14:0] otab[5] = '{15'h3fff, 15'h0001, 15'h0000, 15'h7fff, 15'h4000};
    logic [15:0] rtab[4] = '{16'h0000, 16'h0001, 16'h1000, 16'hffff};

    adc_aux_gain_offset_cal dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .raw_valid(raw_valid), .raw_data(raw_data),
        .pga_gain_sel(pga_gain_sel), .aux_channel(aux_channel), .cal_valid(cal_valid), .cal_data(cal_data));

    always #4 clk = ~clk;

    // Expected result: offset first, then gain with half-up rounding, then clamp
    function automatic logic [15:0] exp_cal(logic [15:0] r, logic [2:0] s, logic a);
        longint v;
        longint c;
        if (!a || (s !== aux_cal_pkg::PGA_GAIN_2 && s !== aux_cal_pkg::PGA_GAIN_4)) return r;
        v = longint'(r) * 4;
        c = (s === aux_cal_pkg::PGA_GAIN_2) ? longint'(g2) : longint'(g4);
        if (s === aux_cal_pkg::PGA_GAIN_4) v = v + longint'($signed(o4));
        v = (v * c + 32768) >>> 16;
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return v[15:0];
    endfunction

    // Address of coefficient register n, and what reading a place should return
    function automatic logic [15:0] reg_addr(int n);
        return (n == 0) ? aux_cal_pkg::OFS_GAIN_CAL_AMP_X2 : (n == 1) ? aux_cal_pkg::OFS_GAIN_CAL_AMP_X4 :
            aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4;
    endfunction

    function automatic logic [31:0] exp_reg(logic [15:0] a);
        if (a == aux_cal_pkg::OFS_GAIN_CAL_AMP_X2) return {17'h0, g2};
        if (a == aux_cal_pkg::OFS_GAIN_CAL_AMP_X4) return {17'h0, g4};
        if (a == aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4) return {17'h0, o4};
        return 32'h0;
    endfunction

    task automatic chk_reg(string what, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_data(logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR cal_data expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_flag(logic e, logic g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR cal_valid expected %b seen %b", e, g);
        end
    endtask

    // Bus write; the bench copy follows only the 15 coefficient bits of mapped places
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge clk);
        raw_valid <= 1'b0;
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        if (a == aux_cal_pkg::OFS_GAIN_CAL_AMP_X2) g2 = d[14:0];
        if (a == aux_cal_pkg::OFS_GAIN_CAL_AMP_X4) g4 = d[14:0];
        if (a == aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4) o4 = d[14:0];
    endtask

    // Bus read; data stand one cycle after the strobe, then the port returns to zero
    task automatic rd(logic [15:0] a, logic [31:0] e);
        @(posedge clk);
        raw_valid <= 1'b0;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk_reg("rdata", e, rdata);
        @(negedge clk);
        chk_reg("rdata_idle", 32'h0, rdata);
    endtask

    // Write, then read the same place on the very next cycle
    task automatic wr_rd(logic [15:0] a, logic [31:0] d);
        @(posedge clk);
        raw_valid <= 1'b0;
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        if (a == aux_cal_pkg::OFS_GAIN_CAL_AMP_X2) g2 = d[14:0];
        if (a == aux_cal_pkg::OFS_GAIN_CAL_AMP_X4) g4 = d[14:0];
        if (a == aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4) o4 = d[14:0];
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk_reg("rdata_after_write", exp_reg(a), rdata);
    endtask

    // One sample; consecutive calls give back-to-back samples
    task automatic samp(logic [15:0] r, logic [2:0] s, logic a);
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_data <= r;
        pga_gain_sel <= s;
        aux_channel <= a;
        expq.push_back(exp_cal(r, s, a));
    endtask

    // Result timing and value, looked at mid-cycle where outputs are settled
    always @(posedge clk) vh <= {vh[0], raw_valid & rstn};
    always @(negedge clk) begin
        if (rstn) begin
            chk_flag(vh[1], cal_valid);
            if (vh[1] && expq.size() > 0) chk_data(expq.pop_front(), cal_data);
        end
    end

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        logic [15:0] a;
        logic [15:0] last;
        int k;
        void'($urandom(28));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Reset values and unmapped places
        rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X2, 32'h00004000);
        rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X4, 32'h00004000);
        rd(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4, 32'h0);
        wr(16'h2276, 32'h00001234);
        rd(16'h2276, 32'h0);
        rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X2, 32'h00004000);
        wr(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4, 32'hffffffff);
        rd(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4, 32'h00007fff);
        wr(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4, 32'h0);
        // Unity defaults pass raw codes through, offset zero adds nothing
        foreach (rtab[i]) samp(rtab[i], aux_cal_pkg::PGA_GAIN_4, 1'b1);
        // Every documented gain code at both gains, zero code included on purpose
        foreach (gtab[i]) begin
            wr(aux_cal_pkg::OFS_GAIN_CAL_AMP_X2, {17'h1ffff, gtab[i]});
            wr_rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X4, {17'h15555, gtab[6 - i]});
            rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X2, {17'h0, gtab[i]});
            foreach (rtab[j]) begin
                samp(rtab[j], aux_cal_pkg::PGA_GAIN_2, 1'b1);
                samp(rtab[j], aux_cal_pkg::PGA_GAIN_4, 1'b1);
                samp(rtab[j], aux_cal_pkg::PGA_GAIN_2, 1'b0);
            end
        end
        // Every documented offset code, with saturation at both ends
        wr(aux_cal_pkg::OFS_GAIN_CAL_AMP_X4, 32'h00007fff);
        foreach (otab[i]) begin
            wr(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4, {17'h0, otab[i]});
            foreach (rtab[j]) samp(rtab[j], aux_cal_pkg::PGA_GAIN_4, 1'b1);
            samp(16'h0800, aux_cal_pkg::PGA_GAIN_2, 1'b1);
        end
        // Sticky saturation flag and last result; let the last sample land first
        last = exp_cal(16'h0800, aux_cal_pkg::PGA_GAIN_2, 1'b1);
        @(posedge clk);
        raw_valid <= 1'b0;
        @(posedge clk);
        rd(aux_cal_pkg::OFS_CAL_STATUS, {15'h0, 1'b1, last});
        wr(aux_cal_pkg::OFS_CAL_STATUS, 32'h00010000);
        rd(aux_cal_pkg::OFS_CAL_STATUS, {15'h0, 1'b0, last});
        // Reset in mid-run brings back the defaults over programmed values
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        g2 = aux_cal_pkg::GAIN_RESET;
        g4 = aux_cal_pkg::GAIN_RESET;
        o4 = aux_cal_pkg::OFFSET_RESET;
        rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X2, exp_reg(aux_cal_pkg::OFS_GAIN_CAL_AMP_X2));
        rd(aux_cal_pkg::OFS_GAIN_CAL_AMP_X4, exp_reg(aux_cal_pkg::OFS_GAIN_CAL_AMP_X4));
        rd(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4, exp_reg(aux_cal_pkg::OFS_OFFSET_CAL_AMP_X4));
        rd(aux_cal_pkg::OFS_CAL_STATUS, 32'h0);
        // Random mix of samples, coefficient writes and reads
        for (int n = 0; n < 400; n++) begin
            k = $urandom_range(0, 9);
            a = reg_addr($urandom_range(0, 2));
            if (k < 3) begin
                wr(a, $urandom());
            end else if (k == 3) begin
                rd(a, exp_reg(a));
            end else if (k == 4) begin
                wr_rd(a, $urandom());
            end else begin
                samp(16'($urandom()), 3'($urandom_range(0, 4)), 1'($urandom()));
            end
        end
        @(posedge clk);
        raw_valid <= 1'b0;
        repeat (4) @(posedge clk);
        chk_reg("pending_results", 32'h0, expq.size());
        close_out();
    end
endmodule
